// ---- hw/irr_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "irr_params.svh"
module irr_top #(
  // identity value, first byte in the top bits; value is arbitrary
  parameter logic [23:0] IDENT_VALUE = 24'h5AC317
)(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [2:0] chip_select_strap_pins,
  output logic            readout_active
);

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  // picks one identity byte; the value is a constant, so no bus write reaches it
  function automatic logic [7:0] irr_byte_sel(input logic [23:0] v, input logic [1:0] i);
    logic [7:0] r;
    r = v[23:16];
    if (i == 2'h1) begin
      r = v[15:8];
    end else if (i == `IRR_ID_LAST) begin
      r = v[7:0];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  irr_pkg::irr_state_t state;
  irr_pkg::irr_state_t next_state;
  logic       link_clear;
  logic       next_link_clear;
  logic       ack_en;
  logic       next_ack_en;
  logic       tx_en;
  logic       next_tx_en;
  logic [1:0] idx;
  logic [1:0] next_idx;
  logic [7:0] tx_byte;
  logic [7:0] next_tx_byte;
  logic [4:0] pin_s;
  logic [1:0] tgl_s;
  logic [1:0] tgl_q;
  logic       sda_prev;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] rx_byte;
  logic       ack_bit;
  logic       byte_tgl;
  logic       slot_tgl;
  logic       next_sda_oe;

  wire        link_rst_n;
  wire        sda_s;
  wire        scl_s;
  wire [2:0]  strap_s;
  wire        start_ev;
  wire        stop_ev;
  wire        byte_ev;
  wire        slot_ev;
  wire        addr_hit;
  wire        byte_done;
  wire        slot_done;
  wire [2:0]  tx_sel;

  // ----------------------------------------------------------------
  // link side, clocked by the serial clock
  // ----------------------------------------------------------------
  // bit engine is cleared while idle and around every start, so a stale
  // count from an abandoned transfer never survives into the next command
  assign link_rst_n   = rstn & ~link_clear;
  assign byte_done    = (bit_cnt == `IRR_BYTE_LAST);
  assign slot_done    = (bit_cnt == `IRR_ACK_SLOT);
  assign next_bit_cnt = slot_done ? `IRR_CNT_RST : 4'(bit_cnt + 4'h1);
  assign tx_sel       = 3'(`IRR_BYTE_LAST - bit_cnt);
  // open drain: only ever pull low, release for a one
  assign next_sda_oe  = slot_done ? ack_en : (tx_en & ~tx_byte[tx_sel]);

  // data sampled while the clock is high
  always_ff @(posedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt  <= `IRR_CNT_RST;
      rx_shift <= 8'h00;
    end else begin
      bit_cnt  <= next_bit_cnt;
      rx_shift <= {rx_shift[6:0], sda_i};
    end
  end

  // toggles survive the link clear; a reset toggle would fake an event
  always_ff @(posedge scl_i or negedge rstn) begin
    if (!rstn) begin
      rx_byte  <= 8'h00;
      ack_bit  <= 1'h1;
      byte_tgl <= 1'h0;
      slot_tgl <= 1'h0;
    end else begin
      if (byte_done) begin
        rx_byte  <= {rx_shift[6:0], sda_i};
        byte_tgl <= ~byte_tgl;
      end
      if (slot_done) begin
        ack_bit  <= sda_i;
        slot_tgl <= ~slot_tgl;
      end
    end
  end

  // drive changes at the falling clock edge; reset or link clear releases it at once
  always_ff @(negedge scl_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe <= 1'h0;
    end else begin
      sda_oe <= next_sda_oe;
    end
  end

  // ----------------------------------------------------------------
  // crossings into the system clock
  // ----------------------------------------------------------------
  irr_sync #(
    .W (5)
  ) u_pin_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({chip_select_strap_pins, scl_i, sda_i}),
    .q    (pin_s)
  );

  irr_sync #(
    .W (2)
  ) u_evt_sync (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({slot_tgl, byte_tgl}),
    .q    (tgl_s)
  );

  assign sda_s    = pin_s[0];
  assign scl_s    = pin_s[1];
  assign strap_s  = pin_s[4:2];
  assign start_ev = scl_s & sda_prev & ~sda_s;
  assign stop_ev  = scl_s & ~sda_prev & sda_s;
  assign byte_ev  = tgl_s[0] ^ tgl_q[0];
  assign slot_ev  = tgl_s[1] ^ tgl_q[1];
  // read/write bit 0 is not compared at all
  assign addr_hit = (rx_byte[`IRR_CODE_HI:`IRR_CODE_LO] == `IRR_DEV_CODE) &&
                    (rx_byte[`IRR_STRAP_HI:`IRR_STRAP_LO] == strap_s);

  // ----------------------------------------------------------------
  // protocol sequencer
  // ----------------------------------------------------------------
  // rx_byte and ack_bit are stable for a whole serial clock after their
  // toggle, so reading them on the synchronised event is safe
  always_comb begin
    next_state      = state;
    next_ack_en     = ack_en;
    next_tx_en      = tx_en;
    next_idx        = idx;
    next_link_clear = link_clear;
    if (stop_ev) begin
      next_state      = irr_pkg::ST_IDLE;
      next_ack_en     = 1'h0;
      next_tx_en      = 1'h0;
      next_link_clear = 1'h1;
    end else if (start_ev) begin
      next_ack_en     = 1'h0;
      next_tx_en      = 1'h0;
      next_link_clear = 1'h1;
      if (state == irr_pkg::ST_WAIT_RS) begin
        next_state = irr_pkg::ST_RSV_RD;
      end else begin
        next_state = irr_pkg::ST_RSV_WR;
      end
    end else begin
      // release the bit engine once the clock has gone low after start
      if (link_clear && !scl_s && state != irr_pkg::ST_IDLE) begin
        next_link_clear = 1'h0;
      end
      if (byte_ev) begin
        case (state)
          irr_pkg::ST_RSV_WR: begin
            if (rx_byte == `IRR_RSV_WR_ID) begin
              next_ack_en = 1'h1;
              next_state  = irr_pkg::ST_DEV_ADDR;
            end else begin
              next_state  = irr_pkg::ST_STANDBY;
            end
          end
          irr_pkg::ST_DEV_ADDR: begin
            if (addr_hit) begin
              next_ack_en = 1'h1;
              next_state  = irr_pkg::ST_WAIT_RS;
            end else begin
              next_state  = irr_pkg::ST_STANDBY;
            end
          end
          irr_pkg::ST_RSV_RD: begin
            if (rx_byte == `IRR_RSV_RD_ID) begin
              next_ack_en = 1'h1;
              next_tx_en  = 1'h1;
              next_idx    = `IRR_ID_FIRST;
              next_state  = irr_pkg::ST_RD_ACK;
            end else begin
              next_state  = irr_pkg::ST_STANDBY;
            end
          end
          irr_pkg::ST_WAIT_RS: begin
            next_state = irr_pkg::ST_STANDBY;
          end
          default: begin
            next_state = state;
          end
        endcase
      end
      if (slot_ev) begin
        next_ack_en = 1'h0;
        case (state)
          irr_pkg::ST_RD_ACK: begin
            next_state = irr_pkg::ST_READ;
          end
          irr_pkg::ST_READ: begin
            if (!ack_bit) begin
              if (idx == `IRR_ID_LAST) begin
                next_idx = `IRR_ID_FIRST;
              end else begin
                next_idx = 2'(idx + 2'h1);
              end
            end else begin
              next_tx_en = 1'h0;
              next_state = irr_pkg::ST_STANDBY;
            end
          end
          default: begin
            next_state = state;
          end
        endcase
      end
    end
  end

  assign next_tx_byte = irr_byte_sel(IDENT_VALUE, next_idx);

  // sequencer registers; the link side samples ack_en, tx_en and tx_byte
  // only at a falling serial clock, long after they settle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state          <= irr_pkg::ST_IDLE;
      link_clear     <= 1'h1;
      ack_en         <= 1'h0;
      tx_en          <= 1'h0;
      idx            <= `IRR_ID_FIRST;
      tx_byte        <= 8'h00;
      tgl_q          <= 2'h0;
      sda_prev       <= 1'h1;
      sda_o          <= 1'h0;
      readout_active <= 1'h0;
    end else if (ce) begin
      state          <= next_state;
      link_clear     <= next_link_clear;
      ack_en         <= next_ack_en;
      tx_en          <= next_tx_en;
      idx            <= next_idx;
      tx_byte        <= next_tx_byte;
      tgl_q          <= tgl_s;
      sda_prev       <= sda_s;
      sda_o          <= 1'h0;
      readout_active <= (next_state == irr_pkg::ST_READ) ||
                        (next_state == irr_pkg::ST_RD_ACK);
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_rsv_wr_in;
    ce && byte_ev && !start_ev && !stop_ev && state == irr_pkg::ST_RSV_WR;
  endsequence

  sequence s_addr_in;
    ce && byte_ev && !start_ev && !stop_ev && state == irr_pkg::ST_DEV_ADDR;
  endsequence

  sequence s_read_slot;
    ce && slot_ev && !start_ev && !stop_ev && state == irr_pkg::ST_READ;
  endsequence

  AST_ID_CONST: assert property (
    tx_en |-> tx_byte == IDENT_VALUE[8 * (`IRR_ID_LAST - idx) +: 8])
    else $error("driven byte differs from the identity value");
  AST_RSV_WR_ACK: assert property (
    s_rsv_wr_in and (rx_byte == `IRR_RSV_WR_ID) |=>
      ack_en && state == irr_pkg::ST_DEV_ADDR)
    else $error("reserved write byte not acknowledged");
  AST_ADDR_ACK: assert property (
    s_addr_in and addr_hit |=> ack_en && state == irr_pkg::ST_WAIT_RS)
    else $error("matching address word not acknowledged");
  AST_RW_IGNORED: assert property (
    s_addr_in and (rx_byte[`IRR_CODE_HI:`IRR_STRAP_LO] ==
      {`IRR_DEV_CODE, strap_s}) |=> ack_en)
    else $error("address word refused because of its read/write bit");
  AST_RD_ENTER: assert property (
    ce && byte_ev && !start_ev && !stop_ev && state == irr_pkg::ST_RSV_RD &&
      rx_byte == `IRR_RSV_RD_ID |=> ack_en && tx_en && idx == `IRR_ID_FIRST ##1 readout_active)
    else $error("reserved read byte did not open the read phase");
  AST_ORDER: assert property (
    s_read_slot and (!ack_bit && idx != `IRR_ID_LAST) |=> idx == 2'($past(idx) + 2'h1))
    else $error("identity bytes out of order");
  AST_NACK_END: assert property (
    s_read_slot and ack_bit |=> !tx_en && state == irr_pkg::ST_STANDBY)
    else $error("not-acknowledge did not end the readout");

  AST_WRAP: assert property (
    s_read_slot and (!ack_bit && idx == `IRR_ID_LAST) |=>
      idx == `IRR_ID_FIRST && tx_byte == IDENT_VALUE[23:16])
    else $error("readout did not wrap to the first byte");

  AST_ADDR_MISS: assert property (
    s_addr_in and !addr_hit |=> !ack_en && state == irr_pkg::ST_STANDBY)
    else $error("foreign address word not sent to standby");

endmodule
`default_nettype wire

// ---- common/irr_params.svh ----
`ifndef IRR_PARAMS_SVH
`define IRR_PARAMS_SVH

// ----------------------------------------------------------------
// reserved slave bytes and address word fields
// ----------------------------------------------------------------
`define IRR_RSV_WR_ID   8'hF8
`define IRR_RSV_RD_ID   8'hF9
`define IRR_DEV_CODE    4'hA
`define IRR_CODE_HI     7
`define IRR_CODE_LO     4
`define IRR_STRAP_HI    3
`define IRR_STRAP_LO    1

// ----------------------------------------------------------------
// bit counting and identity indexing
// ----------------------------------------------------------------
`define IRR_BYTE_LAST   4'h7
`define IRR_ACK_SLOT    4'h8
`define IRR_CNT_RST     4'h0
`define IRR_ID_FIRST    2'h0
`define IRR_ID_LAST     2'h2
`define IRR_ID_BYTES    3

`endif

// ---- common/irr_pkg.sv ----
`default_nettype none
package irr_pkg;

  // protocol phase of the identity readout
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RSV_WR,
    ST_DEV_ADDR,
    ST_WAIT_RS,
    ST_RSV_RD,
    ST_RD_ACK,
    ST_READ,
    ST_STANDBY
  } irr_state_t;

endpackage
`default_nettype wire

// ---- hw/irr_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module irr_sync #(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic     [W-1:0] q
);

  logic [W-1:0] meta;

  // two-stage synchroniser; meta feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q    <= '0;
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// ---- test/irr_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module irr_master #(
  parameter int HALF = 41
)(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ------------------------------------------------------------
  // two-wire bus master model, open drain on the data line
  // ------------------------------------------------------------
  // scl is slower than the 4 ns system clock: the slave decides in the
  // system clock domain and needs a high phase well above 20 ns
  localparam int QTR = HALF / 2;

  // the clock stands high and the data line is let go between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data moves only halfway into the low phase, so it never looks like start/stop;
  // a one is sent by letting go, never by driving high
  task automatic bit_slot(input logic b, output logic got);
    #QTR sda_low = !b;
    #(HALF - QTR) scl = 1'b1;
    #HALF got = sda;
    scl = 1'b0;
  endtask

  // start and repeated start share one shape: let go, clock high, pull low
  task automatic start();
    #QTR sda_low = 1'b0;
    #(HALF - QTR) scl = 1'b1;
    #HALF sda_low = 1'b1;
    #HALF scl = 1'b0;
  endtask

  task automatic stop();
    #QTR sda_low = 1'b1;
    #(HALF - QTR) scl = 1'b1;
    #HALF sda_low = 1'b0;
    #HALF;
  endtask

  // byte out, then the slave's answer bit (1 means not acknowledged)
  task automatic wbyte(input logic [7:0] v, output logic nack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(v[i], g);
    end
    bit_slot(1'b1, nack);
  endtask

  // byte in, then our own acknowledge or not-acknowledge
  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, v[i]);
    end
    bit_slot(!ack, g);
  endtask

  // start, nine released clocks, start, stop
  task automatic recover();
    logic g;
    start();
    for (int i = 0; i < 9; i++) begin
      bit_slot(1'b1, g);
    end
    start();
    stop();
  endtask
endmodule
`default_nettype wire

// ---- test/i2c_identity_readout_and_recovery_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module i2c_identity_readout_and_recovery_bench;
  localparam logic [23:0] IDENT = 24'hC3962E; // test identity, arbitrary
  localparam int          LIMIT = 40000;

  logic       clk;
  logic       rstn;
  logic       ce;
  logic       scl;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe;
  logic       readout_active;
  logic [2:0] straps;
  wire logic  sda;
  int         n_mismatch;
  int         checks_done;
  int         cycles;

  // ------------------------------------------------------------
  // wire, design and master
  // ------------------------------------------------------------
  // pull-up: the line is low only while some party pulls it
  assign sda = !(sda_low || (sda_oe && !sda_o));

  irr_top #(.IDENT_VALUE(IDENT)) dut (
    .clk                    (clk),
    .rstn                   (rstn),
    .ce                     (ce),
    .scl_i                  (scl),
    .sda_i                  (sda),
    .sda_o                  (sda_o),
    .sda_oe                 (sda_oe),
    .chip_select_strap_pins (straps),
    .readout_active         (readout_active)
  );

  irr_master mst (
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // recovery first, then the three-byte opening; e holds the expected nack bits
  task automatic head(input logic [7:0] first, input logic [7:0] aw, input logic [2:0] e);
    logic n;
    mst.recover();
    mst.start();
    mst.wbyte(first, n);
    chk({7'h0, n}, {7'h0, e[2]});
    mst.wbyte(aw, n);
    chk({7'h0, n}, {7'h0, e[1]});
    mst.start();
    mst.wbyte(8'hF9, n);
    chk({7'h0, n}, {7'h0, e[0]});
    repeat (8) @(negedge clk);
    chk({7'h0, readout_active}, {7'h0, e == 3'h0});
  endtask

  // n bytes, acknowledged except the last
  task automatic read_n(input int n);
    logic [7:0] v;
    for (int k = 0; k < n; k++) begin
      mst.rbyte(k != n - 1, v);
      chk(v, IDENT[8 * (2 - k % 3) +: 8]);
    end
    mst.stop();
    repeat (8) @(negedge clk);
    chk({7'h0, readout_active}, 8'h00);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_plain();
    head(8'hF8, {4'hA, 3'h5, 1'b0}, 3'h0);
    read_n(3);
  endtask

  // read bit set, and reads past the third byte wrap to the first
  task automatic t_wrap_rw();
    head(8'hF8, {4'hA, 3'h5, 1'b1}, 3'h0);
    read_n(7);
  endtask

  // wrong code, wrong straps, wrong reserved byte; then the retry works
  task automatic t_refuse();
    head(8'hF8, {4'hB, 3'h5, 1'b0}, 3'h3);
    head(8'hF8, {4'hA, 3'h2, 1'b0}, 3'h3);
    head(8'hF9, {4'hA, 3'h5, 1'b0}, 3'h7);
    @(negedge clk) straps = 3'h2;
    repeat (4) @(negedge clk);
    head(8'hF8, {4'hA, 3'h2, 1'b0}, 3'h0);
    read_n(3);
  endtask

  // readout dropped after one acknowledged byte; recovery restarts from byte one
  task automatic t_abort();
    logic [7:0] v;
    head(8'hF8, {4'hA, 3'h2, 1'b1}, 3'h0);
    mst.rbyte(1'b1, v);
    chk(v, IDENT[23:16]);
    head(8'hF8, {4'hA, 3'h2, 1'b0}, 3'h0);
    read_n(3);
  endtask

  // a stop hidden by a frozen enable leaves the sequencer where it was;
  // a reset in mid-readout lets go of the data line at once
  task automatic t_freeze_reset();
    logic [7:0] v;
    head(8'hF8, {4'hA, 3'h2, 1'b0}, 3'h0);
    @(negedge clk) ce = 1'b0;
    mst.stop();
    repeat (8) @(negedge clk);
    chk({7'h0, readout_active}, 8'h01);
    ce = 1'b1;
    head(8'hF8, {4'hA, 3'h2, 1'b0}, 3'h0);
    mst.rbyte(1'b1, v);
    chk(v, IDENT[23:16]);
    mst.rbyte(1'b1, v);
    chk(v, IDENT[15:8]);
    repeat (2) @(negedge clk);
    chk({7'h0, sda_oe}, {7'h0, !IDENT[7]});
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    chk({6'h0, sda_oe, readout_active}, 8'h00);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    head(8'hF8, {4'hA, 3'h2, 1'b0}, 3'h0);
    read_n(3);
  endtask

  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    cycles = 0;
    rstn = 1'b0;
    ce = 1'b1;
    straps = 3'h5;
    repeat (4) @(negedge clk);
    chk({5'h0, sda_o, sda_oe, readout_active}, 8'h00);
    rstn = 1'b1;
    // synchronisers fill before the first start
    repeat (6) @(negedge clk);
    t_plain();
    t_wrap_rw();
    t_refuse();
    t_abort();
    t_freeze_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
